// ### hdl/adc_port.sv
// converter end: config shift-in, sample, SAR conversion, result shift-out
//
// How it works
// R1 - select falling starts a session
// R2 - select high aborts, enters standby
// R3 - host raises select between conversions
// R4 - config bits taken on sclk rise
// R5 - result pin changes on sclk fall only
// R6 - host clocks start and advance conversion
// R7 - sample held for one and half clocks
// R8 - thirteen clocks, one bit each
// R9 - result spans all 8192 codes
// R10 - two's complement, 1000 to 0FFF
// R11 - out of range clamps, no wrap
// R12 - host picks pseudo-differential for bipolar
// R13 - one-sided use gives twelve-bit range
// R14 - sign bit shifted out first
// R15 - host keeps sclk at least 105 kHz
// R16 - config selects mode and channel; the port reads only the channel bits, the mode bit is ignored
`timescale 1ns/1ps
module adc_port
    import adc_link_pkg::*;
#(
    parameter int NCHAN = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // link pins
    adc_link_if.converter link,
    // analog stand-in: signed difference per channel
    input wire logic signed [15:0] analog_channel_inputs [NCHAN],
    // status toward the user side
    output logic standby,
    output logic [CFG_BITS-1:0] cfg_seen,
    output logic [RES_BITS-1:0] last_code,
    output logic code_valid
);
    typedef enum {ST_STANDBY, ST_START, ST_CFG, ST_ACQ, ST_CONV, ST_DONE} port_state_t;
    port_state_t state_r;

    logic cs_lvl, cs_rise, cs_fall;
    logic ck_lvl, ck_rise, ck_fall;
    logic di_lvl;
    logic [2:0] cfg_cnt_r;
    logic [CFG_BITS-1:0] cfg_r;
    logic [2:0] acq_cnt_r;
    logic [3:0] bit_cnt_r;
    logic signed [15:0] held_r;
    logic [RES_BITS-1:0] code_r;
    logic sdo_r;
    logic sdo_oe_r;
    // decoded frame events, each used by more than one process
    logic deselect;
    logic acq_done;
    logic [RES_BITS-1:0] conv_code;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // select idles high, so its stages reset high
    pin_sync #(.RST_VAL(1'b1)) u_cs (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin(link.select_shutdown_n),
        .level(cs_lvl),
        .rise(cs_rise),
        .fall(cs_fall)
    );
    // serial clock idles low between frames
    pin_sync #(.RST_VAL(1'b0)) u_ck (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin(link.sclk),
        .level(ck_lvl),
        .rise(ck_rise),
        .fall(ck_fall)
    );
    // config data only matters at clock rises, edges unused
    pin_sync #(.RST_VAL(1'b0)) u_di (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin(link.sdi),
        .level(di_lvl),
        .rise(),
        .fall()
    );

    // saturating conversion of the held difference to a 13-bit code
    function automatic logic [RES_BITS-1:0] to_code(input logic signed [15:0] v);
        if (v > $signed({3'b000, CODE_MOST_POS})) begin
            to_code = CODE_MOST_POS; // R11
        end else if (v < -16'sd4096) begin
            to_code = CODE_MOST_NEG; // R11
        end else begin
            to_code = v[RES_BITS-1:0]; // R10
        end
    endfunction

    // ----------------------------------------
    // frame events
    // ----------------------------------------
    // a fall pulse comes while the level still reads high;
    // without this mask every select fall would be swallowed as a deselect
    assign deselect = cs_lvl && !cs_fall; // R2
    // the fall that closes the one and a half clock sample window;
    // pin delay is a few ref_clk cycles, far below a half period
    assign acq_done = (state_r == ST_ACQ) && ck_fall && (acq_cnt_r == 3'(ACQ_HALF_CLKS - 1));
    // one saturated code feeds both the shifter and the status copy
    assign conv_code = to_code(held_r);

    // ----------------------------------------
    // session sequencing
    // ----------------------------------------
    // select high wins over every other event so a partial frame never lingers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_STANDBY;
        end else if (deselect) begin
            state_r <= ST_STANDBY; // R2
        end else begin
            case (state_r)
                ST_STANDBY: if (cs_fall) state_r <= ST_START; // R1
                ST_START: if (ck_rise && di_lvl) state_r <= ST_CFG;
                ST_CFG: if (ck_rise && cfg_cnt_r == 3'(CFG_BITS - 2)) state_r <= ST_ACQ;
                ST_ACQ: if (acq_done) state_r <= ST_CONV;
                ST_CONV: if (ck_fall && bit_cnt_r == 4'(CONV_CLKS - 1)) state_r <= ST_DONE;
                ST_DONE: state_r <= ST_DONE; // R3
                default: state_r <= ST_STANDBY;
            endcase
        end
    end

    // configuration shift-in on sclk rise; start bit then mode and channel
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= '0;
            cfg_cnt_r <= '0;
        end else if (state_r == ST_START && ck_rise && di_lvl) begin
            cfg_r <= {{(CFG_BITS-1){1'b0}}, 1'b1};
            cfg_cnt_r <= '0;
        end else if (state_r == ST_CFG && ck_rise) begin
            cfg_r <= {cfg_r[CFG_BITS-2:0], di_lvl}; // R4 R16
            cfg_cnt_r <= cfg_cnt_r + 3'd1;
        end
    end

    // sample window: counts three sclk half periods, tracking the input
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            acq_cnt_r <= '0;
            held_r <= '0;
        end else if (state_r != ST_ACQ) begin
            acq_cnt_r <= '0;
        end else begin
            if (ck_rise || ck_fall) begin
                acq_cnt_r <= acq_cnt_r + 3'd1; // R7
            end
            // both modes read the one channel named by the channel bits; the mode bit is not used
            held_r <= analog_channel_inputs[cfg_r[CFG_CHAN_MSB:CFG_CHAN_LSB] % NCHAN];
        end
    end

    // successive approximation: one bit per falling edge, sign first
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_r <= '0;
            code_r <= '0;
            sdo_r <= 1'b0;
            sdo_oe_r <= 1'b0;
        end else if (deselect) begin
            bit_cnt_r <= '0;
            sdo_r <= 1'b0; // released pin reads low, never a stale result bit
            sdo_oe_r <= 1'b0; // R2
        end else if (acq_done) begin
            // pin turns on with a null bit; the sign follows one fall later
            code_r <= conv_code; // R9 R13
            sdo_r <= 1'b0;
            sdo_oe_r <= 1'b1;
            bit_cnt_r <= '0;
        end else if (state_r == ST_CONV && ck_fall) begin
            bit_cnt_r <= bit_cnt_r + 4'd1; // R6 R8
            code_r <= {code_r[RES_BITS-2:0], 1'b0};
            sdo_r <= code_r[RES_BITS-1]; // R5 R14
        end
    end

    // user-side status
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            standby <= 1'b1;
            cfg_seen <= '0;
            last_code <= '0;
            code_valid <= 1'b0;
        end else begin
            standby <= (state_r == ST_STANDBY);
            code_valid <= 1'b0;
            // status copies the code at the window close, long before the host has it
            if (acq_done) begin
                cfg_seen <= cfg_r;
                last_code <= conv_code;
                code_valid <= 1'b1;
            end
        end
    end

    assign link.sdo = sdo_r;
    assign link.sdo_oe = sdo_oe_r;
    logic unused_ok;
    assign unused_ok = ck_lvl ^ cs_rise;
endmodule

// ### hdl/adc_link_pkg.sv
// shared constants for the differential converter serial link
package adc_link_pkg;
    // ----------------------------------------
    // result format
    // ----------------------------------------
    localparam int RES_BITS = 13;
    localparam logic [12:0] CODE_MOST_NEG = 13'h1000;
    localparam logic [12:0] CODE_MOST_POS = 13'h0FFF;
    localparam logic [12:0] CODE_FIRST_POS = 13'h0001;
    // ----------------------------------------
    // configuration word layout
    // ----------------------------------------
    localparam int CFG_BITS = 5;
    localparam int CFG_START_POS = 4;
    localparam int CFG_DIFF_POS = 3;
    localparam int CFG_CHAN_MSB = 2;
    localparam int CFG_CHAN_LSB = 0;
    // ----------------------------------------
    // frame timing, in serial clock half periods (sample) and periods (conversion)
    // ----------------------------------------
    localparam int ACQ_HALF_CLKS = 3;
    localparam int CONV_CLKS = 13;
    // ----------------------------------------
    // serial clock from the 200 MHz ref_clk
    // ----------------------------------------
    localparam int REF_CLK_KHZ = 200000;
    localparam int SCLK_MIN_KHZ = 105;
    localparam int SCLK_KHZ = 1000;
    localparam int HALF_PERIOD_CYC = REF_CLK_KHZ / (2 * SCLK_KHZ);
    localparam int SCLK_MAX_HALF_CYC = REF_CLK_KHZ / (2 * SCLK_MIN_KHZ);
endpackage

// ### hdl/adc_link_if.sv
// pins between the serial-bus master and the converter port
`timescale 1ns/1ps
interface adc_link_if;
    logic select_shutdown_n;
    logic sclk;
    logic sdi;
    logic sdo;
    logic sdo_oe;
    modport master (output select_shutdown_n, output sclk, output sdi, input sdo, input sdo_oe);
    modport converter (input select_shutdown_n, input sclk, input sdi, output sdo, output sdo_oe);
endinterface

// ### hdl/pin_sync.sv
// three-stage pin synchroniser with edge pulses
`timescale 1ns/1ps
module pin_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // pin and result
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // first stage feeds only the second
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            // stages start at the pin's idle level, so no false edge follows reset
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            level <= RST_VAL;
        end else if (s2_r == s3_r) begin
            level <= s3_r;
        end
    end

    assign rise = (s2_r == s3_r) && s3_r && !level;
    assign fall = (s2_r == s3_r) && !s3_r && level;
endmodule

// ### hdl/adc_master.sv
// master end: drives select and sclk, sends config, collects result
`timescale 1ns/1ps
module adc_master
    import adc_link_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // link pins
    adc_link_if.master link,
    // request side
    input wire logic start,
    input wire logic [CFG_BITS-2:0] cfg,
    output logic busy,
    // answer side
    output logic [RES_BITS-1:0] result,
    output logic result_valid
);
    typedef enum {M_IDLE, M_LEAD, M_SHIFT, M_GAP} mst_state_t;
    mst_state_t state_r;
    localparam int FRAME_CLKS = CFG_BITS + 2 + CONV_CLKS;
    logic [$clog2(HALF_PERIOD_CYC+1)-1:0] div_r;
    logic half_tick;
    logic [5:0] half_r;
    logic sclk_r;
    logic cs_n_r;
    logic sdi_r;
    logic [CFG_BITS-1:0] cfg_sh_r;
    logic [RES_BITS-1:0] rx_r;
    logic sdo_s1_r, sdo_s2_r, sdo_s3_r;

    // sclk half-period enable; well above the 105 kHz floor
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= '0;
        end else if (state_r == M_IDLE || half_tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1; // R15
        end
    end
    assign half_tick = (div_r == ($bits(div_r))'(HALF_PERIOD_CYC - 1));

    // sdo sampling through three flops
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sdo_s1_r <= 1'b0;
            sdo_s2_r <= 1'b0;
            sdo_s3_r <= 1'b0;
        end else begin
            sdo_s1_r <= link.sdo;
            sdo_s2_r <= sdo_s1_r;
            sdo_s3_r <= sdo_s2_r;
        end
    end

    // frame sequencing: one conversion per select low period
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= M_IDLE;
            cs_n_r <= 1'b1;
            sclk_r <= 1'b0;
            sdi_r <= 1'b0;
            half_r <= '0;
            cfg_sh_r <= '0;
            rx_r <= '0;
            result <= '0;
            result_valid <= 1'b0;
        end else begin
            result_valid <= 1'b0;
            case (state_r)
                M_IDLE: if (start) begin
                    cs_n_r <= 1'b0; // R1
                    cfg_sh_r <= {1'b1, cfg}; // R12 R16
                    half_r <= '0;
                    state_r <= M_LEAD;
                end
                M_LEAD: if (half_tick) begin
                    sdi_r <= cfg_sh_r[CFG_BITS-1]; // R4
                    cfg_sh_r <= {cfg_sh_r[CFG_BITS-2:0], 1'b0};
                    state_r <= M_SHIFT;
                end
                M_SHIFT: if (half_tick) begin
                    sclk_r <= ~sclk_r; // R6
                    half_r <= half_r + 6'd1;
                    if (sclk_r) begin
                        sdi_r <= cfg_sh_r[CFG_BITS-1];
                        cfg_sh_r <= {cfg_sh_r[CFG_BITS-2:0], 1'b0};
                    end else if (half_r >= 6'(2 * (CFG_BITS + 2))) begin
                        rx_r <= {rx_r[RES_BITS-2:0], sdo_s3_r};
                    end
                    if (half_r == 6'(2 * FRAME_CLKS - 1)) begin
                        state_r <= M_GAP;
                    end
                end
                M_GAP: if (half_tick) begin
                    cs_n_r <= 1'b1; // R3
                    sclk_r <= 1'b0;
                    result <= rx_r;
                    result_valid <= 1'b1;
                    state_r <= M_IDLE;
                end
                default: state_r <= M_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
        end else begin
            busy <= (state_r != M_IDLE) || start;
        end
    end

    assign link.select_shutdown_n = cs_n_r;
    assign link.sclk = sclk_r;
    assign link.sdi = sdi_r;
endmodule

// ### sim/adc_link_assertions.sv
// protocol checker watching the link between master and converter ends
`timescale 1ns/1ps
module adc_link_assertions
    import adc_link_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // link pins
    input wire logic select_shutdown_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe
);
    localparam int FRAME_RISES = CFG_BITS + 2 + CONV_CLKS;
    localparam int FRAME_LOW_MAX = (2 * FRAME_RISES + 4) * HALF_PERIOD_CYC;
    logic sclk_r;
    int rise_cnt_r;
    int hold_cnt_r;
    int low_cnt_r;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // helper counts
    // ----------------------------------------
    // clock rises per frame, cleared while the port is deselected
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_r <= 1'b0;
            rise_cnt_r <= 0;
        end else begin
            sclk_r <= sclk;
            if (select_shutdown_n) begin
                rise_cnt_r <= 0;
            end else if (sclk && !sclk_r) begin
                rise_cnt_r <= rise_cnt_r + 1;
            end
        end
    end
    // half-period length and frame length, so slow clocking is caught
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_cnt_r <= 0;
            low_cnt_r <= 0;
        end else begin
            hold_cnt_r <= (select_shutdown_n || sclk != sclk_r) ? 0 : hold_cnt_r + 1;
            low_cnt_r <= select_shutdown_n ? 0 : low_cnt_r + 1;
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    chk_sdo_on_fall: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo) |-> !sclk)
        else $error("result pin moved while serial clock high");
    chk_standby_quiet: assert property (select_shutdown_n [*8] |-> !sdo_oe)
        else $error("result pin driven while deselected");
    chk_release_fast: assert property ($rose(select_shutdown_n) |-> ##[1:8] !sdo_oe)
        else $error("result pin not released after deselect");
    chk_open_quiet: assert property ($fell(select_shutdown_n) |-> !sdo_oe [*8])
        else $error("result pin driven before any clock");
    chk_sdi_steady: assert property ($rose(sclk) && !sdo_oe |-> $stable(sdi))
        else $error("config bit changed at the capturing edge");
    chk_frame_rises: assert property ($rose(select_shutdown_n) |-> rise_cnt_r == FRAME_RISES)
        else $error("wrong number of clock rises in a frame");
    chk_sclk_idle: assert property (select_shutdown_n && $past(select_shutdown_n) |-> !sclk)
        else $error("serial clock running outside a frame");
    chk_clock_rate: assert property (hold_cnt_r <= SCLK_MAX_HALF_CYC)
        else $error("serial clock half period too long");
    chk_frame_bounded: assert property (low_cnt_r <= FRAME_LOW_MAX)
        else $error("select held low past one conversion");
    // main scenarios
    cov_frame_done: cover property ($rose(select_shutdown_n));
    cov_result_driven: cover property ($rose(sdo_oe));
    cov_bit_high: cover property (sdo_oe && sdo);
endmodule

// ### sim/differential_adc_serial_port_test.sv
// self-checking bench: master and converter ends joined over the link
`timescale 1ns/1ps
module differential_adc_serial_port_test;
    import adc_link_pkg::*;
    logic ref_clk;
    logic rst_n;
    logic start;
    logic [CFG_BITS-2:0] cfg;
    logic busy;
    logic [RES_BITS-1:0] result;
    logic result_valid;
    logic signed [15:0] analog_channel_inputs [8];
    logic standby;
    logic [CFG_BITS-1:0] cfg_seen;
    logic [RES_BITS-1:0] last_code;
    logic code_valid;
    logic [RES_BITS-1:0] wire_bits;
    int n_valid;
    int fail_count;
    int n_checks;
    // ----------------------------------------
    // the two ends and the checker
    // ----------------------------------------
    adc_link_if i_adc_link_if ();
    adc_master i_adc_master (.ref_clk(ref_clk), .rst_n(rst_n), .link(i_adc_link_if),
        .start(start), .cfg(cfg), .busy(busy), .result(result), .result_valid(result_valid));
    adc_port #(.NCHAN(8)) i_adc_port (.ref_clk(ref_clk), .rst_n(rst_n), .link(i_adc_link_if),
        .analog_channel_inputs(analog_channel_inputs), .standby(standby),
        .cfg_seen(cfg_seen), .last_code(last_code), .code_valid(code_valid));
    adc_link_assertions i_adc_link_assertions (.ref_clk(ref_clk), .rst_n(rst_n),
        .select_shutdown_n(i_adc_link_if.select_shutdown_n), .sclk(i_adc_link_if.sclk),
        .sdi(i_adc_link_if.sdi), .sdo(i_adc_link_if.sdo), .sdo_oe(i_adc_link_if.sdo_oe));
    // clock, 5 ns period
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // wire monitor: bits as the master sees them, newest in the lsb
    always @(posedge i_adc_link_if.sclk) begin
        if (i_adc_link_if.sdo_oe === 1'b1) wire_bits <= {wire_bits[11:0], i_adc_link_if.sdo};
    end
    // code pulses from the converter, counted per frame by the scenarios
    always @(posedge ref_clk) begin
        if (code_valid === 1'b1) n_valid <= n_valid + 1;
    end
    // ----------------------------------------
    // shared helpers
    // ----------------------------------------
    task automatic check(input logic [12:0] got, input logic [12:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // saturating two's complement code for a signed difference
    function automatic logic [12:0] expect_code(input int v);
        if (v > 4095) return CODE_MOST_POS;
        if (v < -4096) return CODE_MOST_NEG;
        return v[12:0];
    endfunction
    task automatic launch(input logic [3:0] c, input int v);
        @(posedge ref_clk);
        analog_channel_inputs[c[2:0]] <= v[15:0];
        @(posedge ref_clk);
        start <= 1'b1;
        cfg <= c;
        @(posedge ref_clk);
        start <= 1'b0;
    endtask
    // bounded wait; running out counts as a mismatch
    task automatic wait_result();
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (result_valid !== 1'b1 && n < 6000);
        if (result_valid !== 1'b1) begin
            fail_count++;
            $display("Error at %0t: no result before the limit", $time);
        end
    endtask
    task automatic convert(input logic [3:0] c, input int v);
        int seen;
        seen = n_valid;
        launch(c, v);
        repeat (200) @(posedge ref_clk);
        #1;
        check(13'(standby), 13'h0000, "standby in frame");
        check(13'(busy), 13'h0001, "busy in frame");
        wait_result();
        check(13'(n_valid - seen), 13'h0001, "one code per frame");
        check(result, expect_code(v), "result");
        check(wire_bits, expect_code(v), "wire order");
        check(last_code, expect_code(v), "port code");
        check(13'(cfg_seen), 13'({1'b1, c}), "config word");
        repeat (20) @(posedge ref_clk);
        #1;
        check(13'(standby), 13'h0001, "standby after frame");
        check(13'(i_adc_link_if.select_shutdown_n), 13'h0001, "select high");
        check(13'(busy), 13'h0000, "idle after frame");
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_code_table();
        int vals [8] = '{1, -1, 4095, -4096, 5000, -6000, 0, 2047};
        for (int i = 0; i < 8; i++) begin
            convert({i[0], i[2:0]}, vals[i]);
        end
        $display("t_code_table done");
    endtask
    // a second start in mid-frame must not disturb the running one
    task automatic t_busy_refused();
        launch(4'h3, -200);
        repeat (300) @(posedge ref_clk);
        start <= 1'b1;
        cfg <= 4'hD;
        @(posedge ref_clk);
        start <= 1'b0;
        wait_result();
        check(result, expect_code(-200), "refused start result");
        check(13'(cfg_seen), 13'h0013, "refused start config");
        repeat (20) @(posedge ref_clk);
        $display("t_busy_refused done");
    endtask
    // reset in mid-conversion, then a clean frame
    task automatic t_abort_reset();
        launch(4'h6, 1234);
        repeat (1500) @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        check(13'(standby), 13'h0001, "standby in reset");
        check(13'(i_adc_link_if.sdo_oe), 13'h0000, "pin released");
        @(posedge ref_clk);
        rst_n <= 1'b1;
        convert(4'hA, -3);
        $display("t_abort_reset done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // watchdog, about twice the expected run
    initial begin
        repeat (80000) @(posedge ref_clk);
        fail_count++;
        close_out();
    end
    // main sequence
    initial begin
        rst_n = 1'b0;
        start = 1'b0;
        cfg = 4'h0;
        foreach (analog_channel_inputs[i]) analog_channel_inputs[i] = 16'h0000;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_code_table();
        t_busy_refused();
        t_abort_reset();
        close_out();
    end
endmodule
